// ---- rtl/mcu_decode_pkg.sv ----
// Function
// - Instructions are single 14-bit words
// - Destination bit picks accumulator or register
// - Register operand is 7-bit address
// - 3-bit field selects register bit
// - 8-bit literals; call/jump carry 11 bits
// - One cycle; skip or branch takes two
// - Instruction cycle is four clock periods
// - Byte format: 00, opcode, d, address
// - Two-operand byte opcodes and their flags
// - Single-register opcodes and their flags
// - Decrement/increment skip on zero result
// - Bit ops: clear, set, two tests
// - Literal opcodes and their flags
// - Return words pop stack, two cycles
// - Watchdog clear and standby update status
// - Return with literal loads accumulator
// - Port read-modify-write uses pin levels
// - Timer write clears its prescaler
// - Don't-care bits are ignored
// - Taken test discards next instruction
package mcu_decode_pkg;
  localparam int INSTR_W = 14;
  localparam int AXI_AW = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] LAST_PHASE = 2'(OSC_PER_CYCLE - 1);
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC;
  localparam logic [3:0] OP_RLC = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [6:0] CTL_RETURN = 7'h08;
  localparam logic [6:0] CTL_IRET = 7'h09;
  localparam logic [6:0] CTL_SLEEP = 7'h63;
  localparam logic [6:0] CTL_WDT = 7'h64;
  localparam logic [1:0] LIT_LOAD = 2'h0;
  localparam logic [1:0] LIT_RETK = 2'h1;
  localparam logic [3:0] LIT_OR = 4'h8;
  localparam logic [3:0] LIT_AND = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'hA;
  localparam logic [2:0] LIT_SUB = 3'h6;
  localparam logic [2:0] LIT_ADD = 3'h7;
  localparam logic [6:0] FA_TIMER = 7'h01;
  localparam logic [6:0] FA_STATUS = 7'h03;
  localparam logic [6:0] FA_PORT = 7'h05;
  localparam int SB_C = 0;
  localparam int SB_DC = 1;
  localparam int SB_Z = 2;
  localparam int SB_PD = 3;
  localparam int SB_TO = 4;
  localparam logic [4:0] STAT_RST = 5'h18;
  localparam logic [7:0] PRESC_MAX = 8'hFF;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATE = 8'h04;
  localparam logic [AXI_AW-1:0] REG_PC = 8'h08;
  localparam logic [AXI_AW-1:0] REG_TIMER = 8'h0C;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSA = 1;
  localparam int CTRL_WAKE = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;
endpackage

// ---- rtl/mcu_instruction_decoder.sv ----
`timescale 1ns/1ns
module mcu_instruction_decoder
  import mcu_decode_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int STACK_DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire axi_req_s axi_req,
  output axi_rsp_s axi_rsp,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [INSTR_W-1:0] prog_data,
  input wire logic [7:0] port_pins,
  output logic [7:0] port_out,
  output logic sleeping
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef struct packed {
    logic [1:0] phase;
    logic flush;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic [4:0] stat;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [127:0][7:0] ram;
    logic [7:0] presc;
    logic [7:0] port_lat;
    logic [1:0][7:0] pin_sync;
    logic sleeping;
    logic [1:0] ctrl;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic tick;
  logic [INSTR_W-1:0] instr;
  logic [6:0] fa;
  logic [2:0] bsel;
  logic [7:0] fval;
  logic [7:0] kval;
  logic [7:0] res;
  logic [9:0] sum;
  logic cy;
  logic dcy;
  logic wr_f;
  logic wr_acc;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic skip;
  logic is_jump;
  logic is_ret;
  logic is_sleep;

  // Returns {carry, digit carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    instr = prog_data;
    fa = instr[6:0];
    bsel = instr[9:7];
    kval = instr[7:0];
    res = 8'h00;
    sum = 10'h000;
    cy = s_r.stat[SB_C];
    dcy = s_r.stat[SB_DC];
    wr_f = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    skip = 1'b0;
    is_jump = 1'b0;
    is_ret = 1'b0;
    is_sleep = 1'b0;
    s_nxt.pin_sync = {s_r.pin_sync[0], port_pins};
    // Read-modify-write of the port sees the pins, not the latch
    if (fa == FA_STATUS) begin
      fval = {3'h0, s_r.stat};
    end else if (fa == FA_PORT) begin
      fval = s_r.pin_sync[1];
    end else begin
      fval = s_r.ram[fa];
    end
    tick = s_r.ctrl[CTRL_RUN] && !s_r.sleeping && (s_r.phase == LAST_PHASE);

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    if (axi_req.awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req.wdata;
      s_nxt.wstrb = axi_req.wstrb;
    end
    if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      if (s_r.awaddr == REG_CTRL) begin
        s_nxt.bresp = RESP_OKAY;
        if (s_r.wstrb[0]) begin
          s_nxt.ctrl = s_r.wdata[1:0];
          if (s_r.wdata[CTRL_WAKE]) begin
            s_nxt.sleeping = 1'b0;
          end
        end
      end else begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
    if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      case (axi_req.araddr)
        REG_CTRL: s_nxt.rdata = {30'h0, s_r.ctrl};
        REG_STATE: s_nxt.rdata = {18'h0, s_r.sleeping, s_r.stat, s_r.acc};
        REG_PC: s_nxt.rdata = 32'(s_r.pc);
        REG_TIMER: s_nxt.rdata = {16'h0, s_r.presc, s_r.ram[FA_TIMER]};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // ---------------------------------------------------------------
    // Instruction cycle
    // ---------------------------------------------------------------
    if (s_r.ctrl[CTRL_RUN] && !s_r.sleeping) begin
      s_nxt.phase = s_r.phase + 2'h1;
    end
    if (tick) begin
      if (s_r.ctrl[CTRL_PSA]) begin
        s_nxt.presc = s_r.presc + 8'h01;
        if (s_r.presc == PRESC_MAX) begin
          s_nxt.ram[FA_TIMER] = s_r.ram[FA_TIMER] + 8'h01;
        end
      end else begin
        s_nxt.ram[FA_TIMER] = s_r.ram[FA_TIMER] + 8'h01;
      end
      if (s_r.flush) begin
        s_nxt.flush = 1'b0;
      end else begin
        s_nxt.pc = PC_W'(s_r.pc + 1'b1);
        // Wildcard codes leave don't-care bits unread
        unique case (instr[13:12])
          CLS_BYTE: begin
            wr_f = instr[7];
            wr_acc = !instr[7];
            unique case (instr[11:8])
              OP_MISC: begin
                wr_acc = 1'b0;
                if (instr[7]) begin
                  res = s_r.acc;
                end else begin
                  wr_f = 1'b0;
                  if (instr[6:0] == CTL_RETURN || instr[6:0] == CTL_IRET) begin
                    is_ret = 1'b1;
                  end else if (instr[6:0] == CTL_SLEEP) begin
                    is_sleep = 1'b1;
                  end else if (instr[6:0] == CTL_WDT) begin
                    s_nxt.stat[SB_TO] = 1'b1;
                    s_nxt.stat[SB_PD] = 1'b1;
                  end
                end
              end
              OP_CLR: begin
                res = 8'h00;
                upd_z = 1'b1;
              end
              OP_SUB: begin
                sum = add8(fval, ~s_r.acc, 1'b1);
                {upd_c, upd_dc, upd_z} = 3'h7;
              end
              OP_DEC: begin
                res = fval - 8'h01;
                upd_z = 1'b1;
              end
              OP_OR: begin
                res = fval | s_r.acc;
                upd_z = 1'b1;
              end
              OP_AND: begin
                res = fval & s_r.acc;
                upd_z = 1'b1;
              end
              OP_XOR: begin
                res = fval ^ s_r.acc;
                upd_z = 1'b1;
              end
              OP_ADD: begin
                sum = add8(fval, s_r.acc, 1'b0);
                {upd_c, upd_dc, upd_z} = 3'h7;
              end
              OP_MOV: begin
                res = fval;
                upd_z = 1'b1;
              end
              OP_COM: begin
                res = ~fval;
                upd_z = 1'b1;
              end
              OP_INC: begin
                res = fval + 8'h01;
                upd_z = 1'b1;
              end
              OP_DECSZ: begin
                res = fval - 8'h01;
                skip = (res == 8'h00);
              end
              OP_RRC: begin
                res = {s_r.stat[SB_C], fval[7:1]};
                cy = fval[0];
                upd_c = 1'b1;
              end
              OP_RLC: begin
                res = {fval[6:0], s_r.stat[SB_C]};
                cy = fval[7];
                upd_c = 1'b1;
              end
              OP_SWAP: res = {fval[3:0], fval[7:4]};
              OP_INCSZ: begin
                res = fval + 8'h01;
                skip = (res == 8'h00);
              end
            endcase
            if (instr[11:8] == OP_SUB || instr[11:8] == OP_ADD) begin
              {cy, dcy, res} = sum;
            end
          end
          CLS_BIT: begin
            res = fval;
            unique case (instr[11:10])
              2'h0: begin
                res[bsel] = 1'b0;
                wr_f = 1'b1;
              end
              2'h1: begin
                res[bsel] = 1'b1;
                wr_f = 1'b1;
              end
              2'h2: skip = !fval[bsel];
              2'h3: skip = fval[bsel];
            endcase
          end
          CLS_JUMP: begin
            is_jump = 1'b1;
            if (!instr[11]) begin
              s_nxt.stack[s_r.sp] = PC_W'(s_r.pc + 1'b1);
              s_nxt.sp = SP_W'(s_r.sp + 1'b1);
            end
            s_nxt.pc = {{(PC_W-11){1'b0}}, instr[10:0]};
            s_nxt.flush = 1'b1;
          end
          CLS_LIT: begin
            wr_acc = 1'b1;
            // Short prefixes compare only the decoded bits
            if (instr[11:10] == LIT_LOAD) begin
              res = kval;
            end else if (instr[11:10] == LIT_RETK) begin
              res = kval;
              is_ret = 1'b1;
            end else if (instr[11:9] == LIT_SUB) begin
              {cy, dcy, res} = add8(kval, ~s_r.acc, 1'b1);
              {upd_c, upd_dc, upd_z} = 3'h7;
            end else if (instr[11:9] == LIT_ADD) begin
              {cy, dcy, res} = add8(kval, s_r.acc, 1'b0);
              {upd_c, upd_dc, upd_z} = 3'h7;
            end else if (instr[11:8] == LIT_OR) begin
              res = kval | s_r.acc;
              upd_z = 1'b1;
            end else if (instr[11:8] == LIT_AND) begin
              res = kval & s_r.acc;
              upd_z = 1'b1;
            end else if (instr[11:8] == LIT_XOR) begin
              res = kval ^ s_r.acc;
              upd_z = 1'b1;
            end else begin
              wr_acc = 1'b0;
            end
          end
        endcase
        if (is_ret) begin
          s_nxt.sp = SP_W'(s_r.sp - 1'b1);
          s_nxt.pc = s_r.stack[SP_W'(s_r.sp - 1'b1)];
          s_nxt.flush = 1'b1;
        end
        if (is_sleep) begin
          s_nxt.stat[SB_TO] = 1'b1;
          s_nxt.stat[SB_PD] = 1'b0;
          s_nxt.sleeping = 1'b1;
        end
        if (skip) begin
          s_nxt.pc = PC_W'(s_r.pc + 2'h2);
          s_nxt.flush = 1'b1;
        end
        if (wr_acc) begin
          s_nxt.acc = res;
        end
        if (wr_f) begin
          if (fa == FA_STATUS) begin
            s_nxt.stat[2:0] = res[2:0];
          end else if (fa == FA_PORT) begin
            s_nxt.port_lat = res;
          end else begin
            s_nxt.ram[fa] = res;
            if (fa == FA_TIMER && s_r.ctrl[CTRL_PSA]) begin
              s_nxt.presc = 8'h00;
            end
          end
        end
        if (upd_z) begin
          s_nxt.stat[SB_Z] = (res == 8'h00);
        end
        if (upd_c) begin
          s_nxt.stat[SB_C] = cy;
        end
        if (upd_dc) begin
          s_nxt.stat[SB_DC] = dcy;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.stat <= STAT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_rsp = '{awready: s_r.awready, wready: s_r.wready, bvalid: s_r.bvalid,
                     bresp: s_r.bresp, arready: s_r.arready, rvalid: s_r.rvalid,
                     rdata: s_r.rdata, rresp: s_r.rresp};
  assign prog_addr = s_r.pc;
  assign port_out = s_r.port_lat;
  assign sleeping = s_r.sleeping;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exec;
    tick && !s_r.flush;
  endsequence

  sequence s_flush_slot;
    !tick [*3] ##1 tick;
  endsequence

  a_tick_spacing: assert property (tick |=> !tick [*3])
    else $error("instruction ticks closer than four clocks");
  a_skip_discard: assert property (s_exec ##0 skip |=> s_r.flush ##0 s_flush_slot ##1 !s_r.flush)
    else $error("taken skip did not discard one instruction");
  a_flush_nop: assert property (tick && s_r.flush |=> $stable(s_r.acc) && $stable(s_r.pc))
    else $error("discarded instruction changed state");
  a_jump_target: assert property (s_exec ##0 is_jump |=> s_r.pc[10:0] == $past(instr[10:0]) && s_r.flush)
    else $error("jump did not load target");
  a_zero_flag: assert property (s_exec ##0 upd_z |=> s_r.stat[SB_Z] == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  a_dest_acc: assert property (s_exec ##0 (instr[13:12] == CLS_BYTE && !instr[7] && instr[11:8] != OP_MISC) |=> s_r.acc == $past(res))
    else $error("accumulator destination not written");
  a_sleep_flags: assert property (s_exec ##0 is_sleep |=> !s_r.stat[SB_PD] && s_r.stat[SB_TO] && s_r.sleeping)
    else $error("standby did not update status");
  a_timer_presc: assert property (s_exec ##0 (wr_f && fa == FA_TIMER && s_r.ctrl[CTRL_PSA]) |=> s_r.presc == 8'h00)
    else $error("timer write kept prescaler");
  a_return_pop: assert property (s_exec ##0 is_ret |=> s_r.pc == $past(s_r.stack[SP_W'(s_r.sp - 1'b1)]))
    else $error("return did not pop address");
  a_skip_pc: assert property (s_exec ##0 (skip && !is_jump) |=> s_r.pc == PC_W'($past(s_r.pc) + 2'h2))
    else $error("skip did not pass next word");
endmodule // mcu_instruction_decoder

// ---- tb/prog_mem_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Program memory seen by the core
// ----------------------------------------
module prog_mem_model
  import mcu_decode_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int LAT = 1
) (
  input wire logic aclk,
  input wire logic [PC_W-1:0] prog_addr,
  output logic [INSTR_W-1:0] prog_data
);
  logic [INSTR_W-1:0] mem [0:15];
  logic [PC_W-1:0] last_a = '0;
  int age = 0;

  // Settling time after each new address
  always @(posedge aclk) begin
    age <= (prog_addr !== last_a) ? 0 : ((age < LAT) ? age + 1 : age);
    last_a <= prog_addr;
  end

  // One whole word per address; unsettled word shows inverted
  assign prog_data = (prog_addr === last_a && age >= LAT) ?
    mem[prog_addr[3:0]] : ~mem[prog_addr[3:0]];
endmodule // prog_mem_model

// ---- tb/mcu_instruction_decoder_tb.sv ----
`timescale 1ns/1ns
module mcu_instruction_decoder_tb
  import mcu_decode_pkg::*;
;
  // ----------------------------------------
  // Programs (no legacy load words used)
  // ----------------------------------------
  localparam logic [13:0] PROG_A [0:15] = '{14'h33F0, 14'h00A0, 14'h3F1F, 14'h07A0,
    14'h0AA0, 14'h1D03, 14'h3055, 14'h0FA0, 14'h200B, 14'h0820, 14'h280A, 14'h00A0,
    14'h0EA0, 14'h0008, 14'h0000, 14'h0000};
  localparam logic [13:0] PROG_B [0:15] = '{14'h3001, 14'h00A1, 14'h0BA1, 14'h30AA,
    14'h3C03, 14'h0CA1, 14'h0821, 14'h0063, 14'h200C, 14'h0064, 14'h0885, 14'h280B,
    14'h34C3, 14'h0000, 14'h0000, 14'h0000};
  localparam logic [13:0] PROG_C [0:15] = '{14'h3881, 14'h3A0F, 14'h390C, 14'h00A2,
    14'h09A2, 14'h0DA2, 14'h1122, 14'h15A2, 14'h0322, 14'h1822, 14'h3055, 14'h0081,
    14'h01A2, 14'h200F, 14'h0063, 14'h0009};

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axi_req_s axi_req = '0;
  axi_rsp_s axi_rsp;
  logic [12:0] prog_addr;
  logic [INSTR_W-1:0] prog_data;
  logic [7:0] port_pins = 8'h00;
  logic [7:0] port_out;
  logic sleeping;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int cnt = 0;
  logic mon_en = 1'b0;
  logic seen = 1'b0;
  logic [12:0] pa_q = '0;
  logic [31:0] rd;
  logic [1:0] rs;

  always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

  mcu_instruction_decoder i_mcu_instruction_decoder (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .port_pins(port_pins),
    .port_out(port_out),
    .sleeping(sleeping)
  );

  prog_mem_model i_prog_mem_model (
    .aclk(aclk),
    .prog_addr(prog_addr),
    .prog_data(prog_data)
  );

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict;
    end
  end

  // Instruction slot length seen on the program address
  always @(posedge aclk) begin
    if (prog_addr !== pa_q) begin
      if (mon_en && seen) begin
        chk({31'h0, (cnt == 4 || cnt == 8)}, 32'h1);
      end
      seen <= mon_en;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
    pa_q <= prog_addr;
  end

  // ----------------------------------------
  // Register bus access
  // ----------------------------------------
  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                 output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= s;
    axi_req.bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_req.bready && axi_rsp.bvalid) begin
        r = axi_rsp.bresp;
        done = 1'b1;
        axi_req.bready <= 1'b0;
      end
    end
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_req.rready && axi_rsp.rvalid) begin
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        done = 1'b1;
        axi_req.rready <= 1'b0;
      end
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    axi_read(a, rd, rs);
    chk(rd, exp);
    chk_resp(rs, rexp);
  endtask

  task restart(input logic [13:0] p [0:15]);
    aresetn <= 1'b0;
    foreach (p[i]) i_prog_mem_model.mem[i] = p[i];
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    restart(PROG_A);
    chk({10'h0, port_out, sleeping, prog_addr}, 32'h0);
    rd_chk(REG_STATE, 32'h00001800, RESP_OKAY);
    rd_chk(8'h10, 32'h0, RESP_SLVERR);
    axi_write(REG_STATE, 32'h000000FF, 4'hF, rs);
    chk_resp(rs, RESP_SLVERR);
    axi_write(REG_CTRL, 32'h00000001, 4'h0, rs);
    chk_resp(rs, RESP_OKAY);
    rd_chk(REG_CTRL, 32'h0, RESP_OKAY);
    mon_en <= 1'b1;
    axi_write(REG_CTRL, 32'h00000001, 4'hF, rs);
    wait (prog_addr === 13'h00A);
    @(posedge aclk);
    mon_en <= 1'b0;
    rd_chk(REG_STATE, 32'h000018F0, RESP_OKAY);
    rd_chk(REG_CTRL, 32'h00000001, RESP_OKAY);
    port_pins <= 8'hA5;
    restart(PROG_B);
    axi_write(REG_CTRL, 32'h00000001, 4'hF, rs);
    wait (sleeping === 1'b1);
    @(posedge aclk);
    rd_chk(REG_STATE, 32'h00003280, RESP_OKAY);
    axi_write(REG_CTRL, 32'h00000005, 4'hF, rs);
    wait (prog_addr === 13'h00B);
    @(posedge aclk);
    rd_chk(REG_STATE, 32'h00001AC3, RESP_OKAY);
    chk({24'h0, port_out}, 32'h000000A5);
    // Logic literals, bit ops, timer write with prescaler, interrupt return
    restart(PROG_C);
    mon_en <= 1'b1;
    axi_write(REG_CTRL, 32'h00000003, 4'hF, rs);
    wait (sleeping === 1'b1);
    @(posedge aclk);
    rd_chk(REG_STATE, 32'h000035E9, RESP_OKAY);
    rd_chk(REG_TIMER, 32'h000006E9, RESP_OKAY);
    rd_chk(REG_PC, 32'h0000000F, RESP_OKAY);
    print_verdict;
  end
endmodule // mcu_instruction_decoder_tb
